// File: include/cvdc_pkg.sv
// Constants for the converter control block: register indices,
// field positions, reset values, range codes and timing.
// Assumes a 40 MHz system clock and a 32-bit AXI4-Lite register bus.
`default_nettype none
package cvdc_pkg;
  // ----------------------------------------
  // Register indices (byte address = 4 * index)
  // ----------------------------------------
  localparam logic [7:0] IDX_CODE = 8'h01;
  localparam logic [7:0] IDX_CTRL = 8'h55;
  localparam logic [7:0] IDX_SRST = 8'h56;
  localparam logic [7:0] IDX_CFG = 8'h57;
  localparam logic [7:0] IDX_GAIN = 8'h58;
  localparam logic [7:0] IDX_ZERO = 8'h59;
  localparam logic [7:0] IDX_NVM1 = 8'h60;
  localparam logic [7:0] IDX_NVM2 = 8'h61;
  localparam logic [7:0] IDX_NVMD = 8'h63;
  localparam logic [7:0] IDX_STAT = 8'h70;
  localparam logic [7:0] IDX_ROW = 8'h71;
  localparam logic [7:0] IDX_WDOG = 8'h95;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int CTL_RANGE_LSB = 0;
  localparam int CTL_OVR_BIT = 3;
  localparam int CTL_SLEW_BIT = 4;
  localparam int CTL_STEP_LSB = 5;
  localparam int CTL_RATE_LSB = 8;
  localparam int CTL_OUTPUT_DRIVE_ENABLE_BIT = 12;
  localparam int CTL_DUAL_BIT = 13;
  localparam int CTL_CLEAR_LEVEL_SELECT_BIT = 14;
  localparam int CFG_CRC_BIT = 3;
  localparam int CFG_CAL_BIT = 5;
  localparam int CFG_IRANGE_LSB = 8;
  localparam int NVM2_COMMIT_BIT = 0;
  localparam int STS_CRC_BIT = 0;
  localparam int STS_SLEW_BIT = 1;
  localparam int STS_CLR_BIT = 2;
  localparam int CRC_LSB = 24;
  // ----------------------------------------
  // Reset values and codes
  // ----------------------------------------
  localparam logic [15:0] CODE_RST = 16'h0000;
  localparam logic [15:0] CTRL_RST = 16'h0000;
  localparam logic [15:0] CFG_RST = 16'h0400;
  localparam logic [15:0] GAIN_RST = 16'hFFFF;
  localparam logic [15:0] ZERO_RST = 16'h0000;
  localparam logic [15:0] NVM_RST = 16'h0000;
  localparam logic [15:0] MID_CODE = 16'h8000;
  localparam logic [15:0] MAX_CODE = 16'hFFFF;
  localparam logic [7:0] CRC_POLY = 8'h07;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ----------------------------------------
  // Output ranges
  // ----------------------------------------
  typedef enum logic [2:0] {
    R_U5 = 3'b000,
    R_U10 = 3'b001,
    R_B5 = 3'b010,
    R_B10 = 3'b011,
    R_I420 = 3'b100,
    R_I020 = 3'b101,
    R_I024 = 3'b110,
    R_IRSV = 3'b111
  } cvdc_range_t;
  // ----------------------------------------
  // Timing: base slew tick
  // ----------------------------------------
  localparam int CLK_NS = 25;
  localparam int SLEW_BASE_NS = 1000;
  localparam int SLEW_BASE_CYC = SLEW_BASE_NS / CLK_NS;
endpackage : cvdc_pkg
`default_nettype wire

// File: verilog/cvdc_core.sv
// Register map and output control of a single-channel current and
// voltage output converter, reached over AXI4-Lite.
// Assumes one 40 MHz clock; clear pins arrive asynchronously.
//
// Chosen here: the AXI4-Lite slave port.
`default_nettype none
module cvdc_core #(
  parameter int ADDR_W = 12
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic [ADDR_W-1:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  input wire logic [ADDR_W-1:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  input wire logic i_clear_input,
  input wire logic i_clear_level_select_pin,
  output logic [15:0] o_voltage_output_code,
  output logic [15:0] o_current_output_code,
  output logic o_voltage_output_en,
  output logic o_current_output_en,
  output logic [2:0] o_voltage_range,
  output logic [2:0] o_current_range,
  output logic o_voltage_overrange,
  output logic o_frame_check_enable,
  output logic o_watchdog_restart
);
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Index decode; addresses above the index field must be zero
  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    logic [7:0] ix;
    ix = a[9:2];
    is_mapped = (a[ADDR_W-1:10] == '0) && (a[1:0] == 2'h0) &&
      (ix == cvdc_pkg::IDX_CODE || ix == cvdc_pkg::IDX_CTRL ||
       ix == cvdc_pkg::IDX_SRST || ix == cvdc_pkg::IDX_CFG ||
       ix == cvdc_pkg::IDX_GAIN || ix == cvdc_pkg::IDX_ZERO ||
       ix == cvdc_pkg::IDX_NVM1 || ix == cvdc_pkg::IDX_NVM2 ||
       ix == cvdc_pkg::IDX_NVMD || ix == cvdc_pkg::IDX_STAT ||
       ix == cvdc_pkg::IDX_ROW || ix == cvdc_pkg::IDX_WDOG);
  endfunction : is_mapped

  // Byte-lane merge of a 16-bit register
  function automatic logic [15:0] merge(input logic [15:0] old_v,
      input logic [15:0] new_v, input logic [1:0] strb);
    merge = {strb[1] ? new_v[15:8] : old_v[15:8],
             strb[0] ? new_v[7:0] : old_v[7:0]};
  endfunction : merge

  // CRC-8 over index and data, MSB first
  function automatic logic [7:0] crc8(input logic [23:0] d);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 23; i >= 0; i--) begin
      c = (c[7] ^ d[i]) ? ({c[6:0], 1'b0} ^ cvdc_pkg::CRC_POLY)
                        : {c[6:0], 1'b0};
    end
    crc8 = c;
  endfunction : crc8

  // Bipolar voltage ranges
  function automatic logic is_bipolar(input logic [2:0] r);
    is_bipolar = (r == cvdc_pkg::R_B5) || (r == cvdc_pkg::R_B10);
  endfunction : is_bipolar

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic aw_full_reg;
  logic [ADDR_W-1:0] aw_addr_reg;
  logic w_full_reg;
  logic [31:0] w_data_reg;
  logic [1:0] w_strb_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;
  logic do_wr;
  logic [7:0] wr_idx;
  logic wr_map;
  logic crc_bad;
  logic wr_ok;
  logic srst_reg;
  logic core_rst;
  logic [15:0] code_reg;
  logic [15:0] ctrl_reg;
  logic [15:0] cfg_reg;
  logic [15:0] gain_reg;
  logic [15:0] zero_reg;
  logic [15:0] nvm1_reg;
  logic [15:0] nvm2_reg;
  logic [15:0] nvmd_reg;
  logic [15:0] row_reg;
  logic sts_crc_reg;
  logic hold_clr_reg;
  logic wdog_reg;
  logic [2:0] clr_sync_reg;
  logic [2:0] pin_sync_reg;
  logic clr_reg;
  logic pin_reg;
  logic [15:0] corr_code;
  logic [15:0] target;
  logic [15:0] clr_level;
  logic [15:0] slew_reg;
  logic [23:0] tick_cnt_reg;
  logic [23:0] tick_period;
  logic tick;
  logic [15:0] step;
  logic [15:0] out_reg;
  logic [2:0] vrange;
  logic [2:0] irange;
  logic vmode;
  logic dual;

  // ----------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------
  assign o_awready = !aw_full_reg;
  assign o_wready = !w_full_reg;
  assign o_bvalid = bvalid_reg;
  assign o_bresp = bresp_reg;
  assign do_wr = aw_full_reg && w_full_reg && !bvalid_reg;
  assign wr_idx = aw_addr_reg[9:2];
  assign wr_map = is_mapped(aw_addr_reg);
  assign crc_bad = cfg_reg[cvdc_pkg::CFG_CRC_BIT] &&
    (crc8({wr_idx, w_data_reg[15:0]}) != w_data_reg[31:24]);
  assign wr_ok = do_wr && wr_map && !crc_bad;

  // Address and data are caught independently, in either order
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      aw_full_reg <= 1'b0;
      aw_addr_reg <= '0;
    end else if (i_awvalid && !aw_full_reg) begin
      aw_full_reg <= 1'b1;
      aw_addr_reg <= i_awaddr;
    end else if (do_wr) begin
      aw_full_reg <= 1'b0;
    end
  end

  // Write data holding stage
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      w_full_reg <= 1'b0;
      w_data_reg <= '0;
      w_strb_reg <= 2'h0;
    end else if (i_wvalid && !w_full_reg) begin
      w_full_reg <= 1'b1;
      w_data_reg <= i_wdata;
      w_strb_reg <= i_wstrb[1:0];
    end else if (do_wr) begin
      w_full_reg <= 1'b0;
    end
  end

  // Response; a bad check value or unmapped address gives SLVERR
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= cvdc_pkg::RESP_OKAY;
    end else if (do_wr) begin
      bvalid_reg <= 1'b1;
      bresp_reg <= (wr_map && !crc_bad) ? cvdc_pkg::RESP_OKAY
                                        : cvdc_pkg::RESP_SLVERR;
    end else if (i_bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  // ----------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------
  assign o_arready = !rvalid_reg;
  assign o_rvalid = rvalid_reg;
  assign o_rdata = rdata_reg;
  assign o_rresp = rresp_reg;

  // Data register reads back the corrected code when calibration is on, else the raw code
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= '0;
      rresp_reg <= cvdc_pkg::RESP_OKAY;
    end else if (i_arvalid && !rvalid_reg) begin
      rvalid_reg <= 1'b1;
      rresp_reg <= is_mapped(i_araddr) ? cvdc_pkg::RESP_OKAY
                                       : cvdc_pkg::RESP_SLVERR;
      unique case (i_araddr[9:2])
        cvdc_pkg::IDX_CODE: rdata_reg <= {16'h0000, target};
        cvdc_pkg::IDX_CTRL: rdata_reg <= {16'h0000, ctrl_reg};
        cvdc_pkg::IDX_CFG: rdata_reg <= {16'h0000, cfg_reg};
        cvdc_pkg::IDX_GAIN: rdata_reg <= {16'h0000, gain_reg};
        cvdc_pkg::IDX_ZERO: rdata_reg <= {16'h0000, zero_reg};
        cvdc_pkg::IDX_NVM1: rdata_reg <= {16'h0000, nvm1_reg};
        cvdc_pkg::IDX_NVM2: rdata_reg <= {16'h0000, nvm2_reg};
        cvdc_pkg::IDX_NVMD: rdata_reg <= {16'h0000, nvmd_reg};
        cvdc_pkg::IDX_ROW: rdata_reg <= {16'h0000, row_reg};
        cvdc_pkg::IDX_STAT: rdata_reg <= {29'h0, clr_reg,
          (slew_reg != target), sts_crc_reg};
        default: rdata_reg <= 32'h0000_0000;
      endcase
      if (!is_mapped(i_araddr)) begin
        rdata_reg <= 32'h0000_0000;
      end
    end else if (i_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  // ----------------------------------------
  // Software reset and watchdog restart
  // ----------------------------------------
  // reset register write
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      srst_reg <= 1'b0;
      wdog_reg <= 1'b0;
    end else begin
      srst_reg <= wr_ok && (wr_idx == cvdc_pkg::IDX_SRST);
      wdog_reg <= wr_ok && (wr_idx == cvdc_pkg::IDX_WDOG);
    end
  end
  // Bus handshake survives the soft reset so the response still lands
  assign core_rst = !i_rstn || srst_reg;
  assign o_watchdog_restart = wdog_reg;

  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  // read-only registers take no writes; 16-bit calibration
  always_ff @(posedge i_clk) begin
    if (core_rst) begin
      ctrl_reg <= cvdc_pkg::CTRL_RST;
      cfg_reg <= cvdc_pkg::CFG_RST;
      gain_reg <= cvdc_pkg::GAIN_RST;
      zero_reg <= cvdc_pkg::ZERO_RST;
      nvm1_reg <= cvdc_pkg::NVM_RST;
      nvm2_reg <= cvdc_pkg::NVM_RST;
      nvmd_reg <= cvdc_pkg::NVM_RST;
    end else if (wr_ok) begin
      unique case (wr_idx)
        cvdc_pkg::IDX_CTRL: ctrl_reg <= merge(ctrl_reg, w_data_reg[15:0], w_strb_reg);
        cvdc_pkg::IDX_CFG: cfg_reg <= merge(cfg_reg, w_data_reg[15:0], w_strb_reg);
        cvdc_pkg::IDX_GAIN: gain_reg <= merge(gain_reg, w_data_reg[15:0], w_strb_reg);
        cvdc_pkg::IDX_ZERO: zero_reg <= merge(zero_reg, w_data_reg[15:0], w_strb_reg);
        cvdc_pkg::IDX_NVM1: nvm1_reg <= merge(nvm1_reg, w_data_reg[15:0], w_strb_reg);
        cvdc_pkg::IDX_NVM2: nvm2_reg <= merge(nvm2_reg, w_data_reg[15:0], w_strb_reg);
        cvdc_pkg::IDX_NVMD: nvmd_reg <= merge(nvmd_reg, w_data_reg[15:0], w_strb_reg);
        default: ;
      endcase
    end
  end

  // Row readback is loaded from the NVM data register on a commit
  always_ff @(posedge i_clk) begin
    if (core_rst) begin
      row_reg <= cvdc_pkg::NVM_RST;
    end else if (wr_ok && wr_idx == cvdc_pkg::IDX_NVM2 &&
                 w_strb_reg[0] && w_data_reg[cvdc_pkg::NVM2_COMMIT_BIT]) begin
      row_reg <= nvmd_reg;
    end
  end

  // Check-value error flag: cleared by a status read, a new error wins
  always_ff @(posedge i_clk) begin
    if (core_rst) begin
      sts_crc_reg <= 1'b0;
    end else if (do_wr && wr_map && crc_bad) begin
      sts_crc_reg <= 1'b1;
    end else if (i_arvalid && !rvalid_reg && is_mapped(i_araddr) &&
                 i_araddr[9:2] == cvdc_pkg::IDX_STAT) begin
      sts_crc_reg <= 1'b0;
    end
  end

  // Data code; a range change wipes it and holds the clear level
  always_ff @(posedge i_clk) begin
    if (core_rst) begin
      code_reg <= cvdc_pkg::CODE_RST;
      hold_clr_reg <= 1'b1;
    end else if (wr_ok && wr_idx == cvdc_pkg::IDX_CODE) begin
      code_reg <= merge(code_reg, w_data_reg[15:0], w_strb_reg);
      hold_clr_reg <= 1'b0;
    end else if (wr_ok && wr_idx == cvdc_pkg::IDX_CTRL && w_strb_reg[0] &&
                 w_data_reg[2:0] != ctrl_reg[2:0]) begin
      code_reg <= cvdc_pkg::CODE_RST;
      hold_clr_reg <= 1'b1;
    end
  end

  // ----------------------------------------
  // Clear pins: three stages, change taken when the last two agree
  // ----------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      clr_sync_reg <= 3'h0;
      pin_sync_reg <= 3'h0;
      clr_reg <= 1'b0;
      pin_reg <= 1'b0;
    end else begin
      clr_sync_reg <= {clr_sync_reg[1:0], i_clear_input};
      pin_sync_reg <= {pin_sync_reg[1:0], i_clear_level_select_pin};
      if (clr_sync_reg[1] == clr_sync_reg[2]) begin
        clr_reg <= clr_sync_reg[2];
      end
      if (pin_sync_reg[1] == pin_sync_reg[2]) begin
        pin_reg <= pin_sync_reg[2];
      end
    end
  end

  // ----------------------------------------
  // Range decode and clear level
  // ----------------------------------------
  assign vrange = ctrl_reg[cvdc_pkg::CTL_RANGE_LSB +: 3];
  assign vmode = !vrange[2];
  assign dual = ctrl_reg[cvdc_pkg::CTL_DUAL_BIT];
  assign irange = dual ? cfg_reg[cvdc_pkg::CFG_IRANGE_LSB +: 3] : vrange;

  always_comb begin
    if (pin_reg || ctrl_reg[cvdc_pkg::CTL_CLEAR_LEVEL_SELECT_BIT]) begin
      clr_level = is_bipolar(vrange) ? cvdc_pkg::CODE_RST : cvdc_pkg::MID_CODE;
    end else begin
      clr_level = is_bipolar(vrange) ? cvdc_pkg::MID_CODE : cvdc_pkg::CODE_RST;
    end
  end

  // ----------------------------------------
  // Calibration: code * (gain + 1) / 65536 + signed zero, clamped
  // ----------------------------------------
  always_comb begin
    logic [32:0] prod;
    logic signed [18:0] sum;
    prod = 33'(code_reg) * 33'(gain_reg) + 33'(code_reg);
    sum = $signed({2'b00, prod[32:16]}) + 19'($signed(zero_reg));
    if (sum < 0) begin
      corr_code = 16'h0000;
    end else if (sum > $signed({3'b000, cvdc_pkg::MAX_CODE})) begin
      corr_code = cvdc_pkg::MAX_CODE;
    end else begin
      corr_code = sum[15:0];
    end
  end
  assign target = cfg_reg[cvdc_pkg::CFG_CAL_BIT] ? corr_code : code_reg;

  // ----------------------------------------
  // Slew: base tick scaled by two to the rate select
  // ----------------------------------------
  assign tick_period = 24'(cvdc_pkg::SLEW_BASE_CYC) <<
    ctrl_reg[cvdc_pkg::CTL_RATE_LSB +: 4];
  assign tick = (tick_cnt_reg >= tick_period - 24'h1);
  assign step = 16'h1 << ctrl_reg[cvdc_pkg::CTL_STEP_LSB +: 3];

  // Tick counter restarts whenever slewing is off
  always_ff @(posedge i_clk) begin
    if (core_rst || !ctrl_reg[cvdc_pkg::CTL_SLEW_BIT] || tick) begin
      tick_cnt_reg <= 24'h0;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 24'h1;
    end
  end

  // ramp only while enabled; steps never overshoot the target
  always_ff @(posedge i_clk) begin
    if (core_rst) begin
      slew_reg <= cvdc_pkg::CODE_RST;
    end else if (!ctrl_reg[cvdc_pkg::CTL_SLEW_BIT]) begin
      slew_reg <= target;
    end else if (tick) begin
      if (target > slew_reg) begin
        slew_reg <= (target - slew_reg <= step) ? target : slew_reg + step;
      end else if (target < slew_reg) begin
        slew_reg <= (slew_reg - target <= step) ? target : slew_reg - step;
      end
    end
  end

  // ----------------------------------------
  // Output stage
  // ----------------------------------------
  // clear state; level after reset until code rewritten
  always_ff @(posedge i_clk) begin
    if (core_rst) begin
      out_reg <= cvdc_pkg::CODE_RST;
    end else if (clr_reg || hold_clr_reg) begin
      out_reg <= clr_level;
    end else begin
      out_reg <= slew_reg;
    end
  end

  assign o_voltage_output_code = out_reg;
  assign o_current_output_code = out_reg;
  // enable selected output; both in dual mode
  assign o_voltage_output_en = ctrl_reg[cvdc_pkg::CTL_OUTPUT_DRIVE_ENABLE_BIT] && (vmode || dual);
  assign o_current_output_en = ctrl_reg[cvdc_pkg::CTL_OUTPUT_DRIVE_ENABLE_BIT] && (!vmode || dual);
  assign o_voltage_range = vmode ? vrange : cvdc_pkg::R_U5;
  assign o_current_range = irange;
  assign o_voltage_overrange = ctrl_reg[cvdc_pkg::CTL_OVR_BIT];
  assign o_frame_check_enable = cfg_reg[cvdc_pkg::CFG_CRC_BIT];
endmodule : cvdc_core
`default_nettype wire

// File: verif/cvdc_checker.sv
// Checker: bus answers and output levels.
// Assumes it is bound to cvdc_core and sees only that module's ports.
`default_nettype none
module cvdc_checker #(parameter int ADDR_W = 12) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic [ADDR_W-1:0] i_araddr,
  input wire logic i_arvalid,
  input wire logic o_arready,
  input wire logic [31:0] o_rdata,
  input wire logic [1:0] o_rresp,
  input wire logic o_rvalid,
  input wire logic i_rready,
  input wire logic [1:0] o_bresp,
  input wire logic o_bvalid,
  input wire logic i_bready,
  input wire logic i_clear_input,
  input wire logic i_clear_level_select_pin,
  input wire logic [15:0] o_voltage_output_code,
  input wire logic [15:0] o_current_output_code,
  input wire logic [2:0] o_voltage_range,
  input wire logic o_watchdog_restart
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  chk_read_answer: assert property (i_arvalid && o_arready |=> o_rvalid)
    else $error("read not answered");
  chk_rdata_hold: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
    else $error("read data moved");
  chk_read_block: assert property (o_rvalid |-> !o_arready)
    else $error("address taken while busy");
  chk_unmapped_read: assert property (i_arvalid && o_arready && i_araddr == 12'h3FC
    |=> o_rresp == 2'h2 && o_rdata == 32'h0) else $error("unmapped read not refused");
  chk_resp_hold: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
    else $error("response moved");
  chk_resp_drop: assert property (o_bvalid && i_bready |=> !o_bvalid)
    else $error("response not dropped");
  chk_wdog_pulse: assert property (o_watchdog_restart |=> !o_watchdog_restart)
    else $error("watchdog pulse too long");
  chk_shared_code: assert property (o_voltage_output_code == o_current_output_code)
    else $error("outputs differ");
  // Held clear with pin high
  chk_clear_level: assert property ((i_clear_input && i_clear_level_select_pin)[*8]
    ##0 !o_voltage_range[2] |-> o_voltage_output_code == (o_voltage_range[1] ? 16'h0000
    : 16'h8000)) else $error("clear level wrong");
endmodule : cvdc_checker
bind cvdc_core cvdc_checker #(.ADDR_W(ADDR_W)) u_chk (.*);
`default_nettype wire

// File: verif/cvdc_host.sv
// Host model: AXI4-Lite master, one transfer at a time.
// Assumes a single clock; the bench calls wr and rd hierarchically.
`default_nettype none
module cvdc_host (
  input wire logic i_clk,
  output logic [11:0] o_awaddr,
  output logic o_awvalid,
  input wire logic i_awready,
  output logic [31:0] o_wdata,
  output logic [3:0] o_wstrb,
  output logic o_wvalid,
  input wire logic i_wready,
  input wire logic [1:0] i_bresp,
  input wire logic i_bvalid,
  output logic o_bready,
  output logic [11:0] o_araddr,
  output logic o_arvalid,
  input wire logic i_arready,
  input wire logic [31:0] i_rdata,
  input wire logic [1:0] i_rresp,
  input wire logic i_rvalid,
  output logic o_rready
);
  timeunit 1ns;
  timeprecision 1ps;
  bit lag;
  logic crc_on;
  // ----------------------------------------
  // Bus tasks; lag delays ready
  // ----------------------------------------
  initial begin
    {o_awaddr, o_awvalid, o_wdata, o_wstrb, o_wvalid, o_bready} = '0;
    {o_araddr, o_arvalid, o_rready, crc_on} = '0;
  end
  function automatic logic [7:0] crc8(input logic [23:0] m);
    logic [7:0] x;
    x = 8'h00;
    for (int i = 23; i >= 0; i--) x = {x[6:0], 1'b0} ^ ((x[7] ^ m[i]) ? 8'h07 : 8'h00);
    return x;
  endfunction : crc8
  task automatic wr(input logic [7:0] a, logic [15:0] v, logic bad, output logic [1:0] r);
    logic ta, tk, tb, sb;
    @(posedge i_clk);
    o_awaddr <= {2'b00, a, 2'b00};
    o_awvalid <= 1'b1;
    o_wdata <= {crc_on ? crc8({a, v}) ^ {8{bad}} : 8'h00, 8'h00, v};
    o_wstrb <= 4'h3;
    o_wvalid <= 1'b1;
    o_bready <= !lag;
    do begin
      @(negedge i_clk);
      ta = o_awvalid && i_awready;
      tk = o_wvalid && i_wready;
      tb = i_bvalid && o_bready;
      sb = i_bvalid;
      r = i_bresp;
      @(posedge i_clk);
      o_awvalid <= o_awvalid && !ta;
      o_wvalid <= o_wvalid && !tk;
      // Released lines invert so stale values stand out
      if (ta) o_awaddr <= ~o_awaddr;
      if (tk) o_wdata <= ~o_wdata;
      if (sb && !tb) o_bready <= 1'b1;
    end while (!tb);
    o_bready <= 1'b0;
    if (r == 2'h0 && a == cvdc_pkg::IDX_CFG) crc_on = v[cvdc_pkg::CFG_CRC_BIT];
    if (r == 2'h0 && a == cvdc_pkg::IDX_SRST) crc_on = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ta, tb, sb;
    @(posedge i_clk);
    o_araddr <= {2'b00, a, 2'b00};
    o_arvalid <= 1'b1;
    o_rready <= !lag;
    do begin
      @(negedge i_clk);
      ta = o_arvalid && i_arready;
      tb = i_rvalid && o_rready;
      sb = i_rvalid;
      d = i_rdata;
      r = i_rresp;
      @(posedge i_clk);
      o_arvalid <= o_arvalid && !ta;
      if (ta) o_araddr <= ~o_araddr;
      if (sb && !tb) o_rready <= 1'b1;
    end while (!tb);
    o_rready <= 1'b0;
  endtask : rd
endmodule : cvdc_host
`default_nettype wire

// File: verif/current_voltage_dac_control_test.sv
// Bench for the converter control block.
// Assumes the host model drives the bus and the checker is bound to u_dut.
`default_nettype none
module current_voltage_dac_control_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [1:0] OK = cvdc_pkg::RESP_OKAY;
  localparam logic [1:0] SLV = cvdc_pkg::RESP_SLVERR;
  localparam logic [7:0] RI [6] = '{8'h01, 8'h55, 8'h57, 8'h58, 8'h59, 8'h95};
  localparam logic [15:0] RV [6] = '{cvdc_pkg::CODE_RST, cvdc_pkg::CTRL_RST,
    cvdc_pkg::CFG_RST, cvdc_pkg::GAIN_RST, cvdc_pkg::ZERO_RST, 16'h0000};
  localparam logic [15:0] GT [4] = '{16'h7FFF, 16'hFFFF, 16'h0000, 16'hFFFF};
  localparam logic [15:0] ZT [4] = '{16'h0010, 16'hFFF0, 16'h7FFF, 16'h7FFF};
  localparam logic [7:0] IC = cvdc_pkg::IDX_CODE, IT = cvdc_pkg::IDX_CTRL;
  localparam logic [7:0] IG = cvdc_pkg::IDX_CFG, IS = cvdc_pkg::IDX_STAT;
  logic i_clk, i_rstn, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready;
  logic i_clear_input, i_clear_level_select_pin, o_awready, o_wready, o_bvalid;
  logic o_arready, o_rvalid, o_voltage_output_en, o_current_output_en;
  logic o_voltage_overrange, o_frame_check_enable, o_watchdog_restart;
  logic [11:0] i_awaddr, i_araddr;
  logic [31:0] i_wdata, o_rdata, d;
  logic [3:0] i_wstrb;
  logic [1:0] o_bresp, o_rresp, r;
  logic [15:0] o_voltage_output_code, o_current_output_code, c;
  logic [2:0] o_voltage_range, o_current_range;
  int n_mismatch, checks_done, cyc, n_wd, n0;
  cvdc_core u_dut (.*);
  cvdc_host u_host (.i_clk, .o_awaddr(i_awaddr), .o_awvalid(i_awvalid), .i_awready(o_awready),
    .o_wdata(i_wdata), .o_wstrb(i_wstrb), .o_wvalid(i_wvalid), .i_wready(o_wready),
    .i_bresp(o_bresp), .i_bvalid(o_bvalid), .o_bready(i_bready), .o_araddr(i_araddr),
    .o_arvalid(i_arvalid), .i_arready(o_arready), .i_rdata(o_rdata), .i_rresp(o_rresp),
    .i_rvalid(o_rvalid), .o_rready(i_rready));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : chk
  // Sample at the falling edge, clear of races
  task automatic tw(logic [7:0] a, logic [15:0] v, logic b, logic [1:0] e);
    u_host.lag = 1'($urandom);
    u_host.wr(a, v, b, r);
    @(negedge i_clk);
    chk(r, e);
  endtask : tw
  task automatic tr(logic [7:0] a, logic [31:0] v, logic [1:0] e);
    u_host.lag = 1'($urandom);
    u_host.rd(a, d, r);
    @(negedge i_clk);
    chk(d, v);
    chk(r, e);
  endtask : tr
  function automatic logic [15:0] cal(input logic [15:0] x, g, z);
    int s;
    s = int'((32'(x) * (32'(g) + 32'h1)) >> 16) + int'(signed'(z));
    return s < 0 ? 16'h0000 : (s > 65535 ? 16'hFFFF : 16'(s));
  endfunction : cal
  function automatic logic [15:0] clv(input logic bip, input logic mid);
    return (bip ^ mid) ? 16'h8000 : 16'h0000;
  endfunction : clv
  task automatic end_of_test();
    $display("checks_done %0d n_mismatch %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : end_of_test
  initial begin
    i_clk = 1'b0;
    forever #12.5 i_clk = ~i_clk;
  end
  // Hang guard
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 8000) begin
      n_mismatch++;
      end_of_test();
    end
  end
  always @(negedge i_clk) if (o_watchdog_restart === 1'b1) n_wd++;
  initial begin
    {i_rstn, i_clear_input, i_clear_level_select_pin} = 3'b000;
    c = 16'($urandom(32'h5B14D13A));
    repeat (16) @(posedge i_clk);
    i_rstn <= 1'b1;
    for (int k = 0; k < 6; k++) tr(RI[k], RV[k], OK);
    repeat (4) begin
      c = 16'($urandom);
      tw(IC, c, 0, OK);
      tr(IC, c, OK);
      chk(o_current_output_code, c);
    end
    $display("test code done");
    tw(IT, 16'h1001, 0, OK);
    tr(IC, 0, OK);
    chk({o_voltage_output_en, o_current_output_en}, 2'b10);
    tw(IC, 16'h1234, 0, OK);
    tw(IT, 16'h1009, 0, OK);
    tr(IC, 16'h1234, OK);
    chk(o_voltage_overrange, 1);
    tw(IG, 16'h0500, 0, OK);
    tw(IT, 16'h3001, 0, OK);
    chk({o_voltage_output_en, o_current_output_en, o_current_range}, 5'h1D);
    tw(IT, 16'h2001, 0, OK);
    chk({o_voltage_output_en, o_current_output_en}, 2'b00);
    c = 16'h1F11 | 16'(($urandom & 7) << 5);
    tw(IT, c, 0, OK);
    tr(IT, c, OK);
    tw(IC, 16'hFFFF, 0, OK);
    tr(IS, 32'h2, OK);
    chk(o_voltage_output_code === 16'hFFFF, 0);
    tw(IT, 16'h1001, 0, OK);
    repeat (2) @(negedge i_clk);
    chk(o_voltage_output_code, 16'hFFFF);
    $display("test slew done");
    for (int k = 0; k < 4; k++) begin
      c = 16'($urandom);
      tw(cvdc_pkg::IDX_GAIN, GT[k], 0, OK);
      tw(cvdc_pkg::IDX_ZERO, ZT[k], 0, OK);
      tr(cvdc_pkg::IDX_ZERO, ZT[k], OK);
      tw(IG, 16'h0420, 0, OK);
      tw(IC, c, 0, OK);
      tr(IC, cal(c, GT[k], ZT[k]), OK);
    end
    tw(IG, 16'h0408, 0, OK);
    chk(o_frame_check_enable, 1);
    tw(IC, 16'h4321, 0, OK);
    tw(IC, 16'h5555, 1, SLV);
    tr(IC, 16'h4321, OK);
    tr(IS, 32'h1, OK);
    tr(IS, 32'h0, OK);
    tw(IG, 16'h0400, 0, OK);
    tw(IS, 16'hFFFF, 0, OK);
    tw(cvdc_pkg::IDX_ROW, 16'hFFFF, 0, OK);
    tr(cvdc_pkg::IDX_ROW, 0, OK);
    tw(8'hFF, 16'h0001, 0, SLV);
    tr(8'hFF, 0, SLV);
    $display("test cal done");
    for (int k = 0; k < 8; k++) begin
      tw(IT, 16'(k[0]) << 14 | 16'(k[1]) << 1, 0, OK);
      @(posedge i_clk);
      i_clear_level_select_pin <= k[2];
      i_clear_input <= 1'b1;
      repeat (8) @(negedge i_clk);
      chk(o_voltage_output_code, clv(k[1], k[0] | k[2]));
      @(posedge i_clk);
      i_clear_input <= 1'b0;
    end
    n0 = n_wd;
    tw(cvdc_pkg::IDX_WDOG, 16'h0000, 0, OK);
    chk(n_wd - n0, 1);
    tw(cvdc_pkg::IDX_SRST, 16'h0001, 0, OK);
    for (int k = 0; k < 6; k++) tr(RI[k], RV[k], OK);
    chk(o_voltage_output_code, 16'h8000);
    $display("test clear done");
    end_of_test();
  end
endmodule : current_voltage_dac_control_test
`default_nettype wire
